// >>> dv/ptpwm_core_bench.sv
// Self-checking bench of the PI thermostat with PWM output
`timescale 1ns/100ps
module ptpwm_core_bench;
    import ptpwm_pkg::*;
    localparam int LIMIT = 20000;
    logic ref_clk_i;
    logic rstn_i;
    logic sample_tick_i;
    ptpwm_cfg_t cfg_i;
    ptpwm_spmode_t setpoint_mode_i;
    ptpwm_setpoints_t presets_i;
    ptpwm_window_t window_i;
    logic season_datapoint_type_i;
    logic setpoint_wr_i;
    logic signed [TEMP_W-1:0] setpoint_i;
    logic signed [TEMP_W-1:0] meas_temp_i;
    logic nv_valid_i;
    logic signed [TEMP_W-1:0] nv_setpoint_i;
    logic nv_store_o;
    logic signed [TEMP_W-1:0] nv_data_o;
    logic [CV_W-1:0] control_pct_o;
    logic pwm_out_o;
    logic cycle_start_o;
    logic window_open_o;
    logic mode_supported_o;
    logic signed [TEMP_W-1:0] active_setpoint_o;
    int bad_count = 0;
    int n_checks = 0;
    int cyc_cnt = 0;

    ptpwm_core u_dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .sample_tick_i(sample_tick_i),
        .cfg_i(cfg_i), .setpoint_mode_i(setpoint_mode_i), .presets_i(presets_i),
        .window_i(window_i), .season_datapoint_type_i(season_datapoint_type_i),
        .setpoint_wr_i(setpoint_wr_i), .setpoint_i(setpoint_i), .meas_temp_i(meas_temp_i),
        .nv_valid_i(nv_valid_i), .nv_setpoint_i(nv_setpoint_i), .nv_store_o(nv_store_o),
        .nv_data_o(nv_data_o), .control_pct_o(control_pct_o), .pwm_out_o(pwm_out_o),
        .cycle_start_o(cycle_start_o), .window_open_o(window_open_o),
        .mode_supported_o(mode_supported_o), .active_setpoint_o(active_setpoint_o));
    ptpwm_nvm_model u_nvm (.ref_clk_i(ref_clk_i), .store_i(nv_store_o), .data_i(nv_data_o),
        .valid_o(nv_valid_i), .data_o(nv_setpoint_i));

    initial
    begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end

    task automatic stop_test();
        if (bad_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // ----------------------------------------
    // Bus-side helpers
    // ----------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    task automatic do_reset();
        @(posedge ref_clk_i);
        rstn_i <= 1'b0;
        cyc(4);
        rstn_i <= 1'b1;
        cyc(60);
    endtask

    task automatic write_sp(input logic [15:0] v, input logic exp_store);
        @(posedge ref_clk_i);
        setpoint_i <= v;
        setpoint_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        setpoint_wr_i <= 1'b0;
        @(posedge ref_clk_i);
        check("nv_store", nv_store_o, exp_store);
        if (exp_store)
            check("nv_data", nv_data_o, v);
    endtask

    task automatic tick();
        @(posedge ref_clk_i);
        sample_tick_i <= 1'b1;
        @(posedge ref_clk_i);
        sample_tick_i <= 1'b0;
        cyc(60);
    endtask

    task automatic run_cycle(input logic [15:0] sp, input logic [6:0] exp);
        int i;
        write_sp(sp, 1'b1);
        for (i = 0; i < 100 && cycle_start_o !== 1'b1; i++)
            @(posedge ref_clk_i);
        check("cycle_start", cycle_start_o, 1'b1);
        cyc(3);
        check("control_pct", control_pct_o, exp);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_defaults();
        check("default_heat", active_setpoint_o, 16'h00d2);
        season_datapoint_type_i <= 1'b0;
        cyc(3);
        check("default_cool", active_setpoint_o, 16'h0104);
        season_datapoint_type_i <= 1'b1;
        cyc(3);
    endtask

    task automatic t_law();
        meas_temp_i <= 16'h00b4;
        run_cycle(16'h00c8, 7'h32);
        check("active_sp", active_setpoint_o, 16'h00c8);
        season_datapoint_type_i <= 1'b0;
        meas_temp_i <= 16'h00dc;
        run_cycle(16'h00c8, 7'h32);
        meas_temp_i <= 16'h00b4;
        run_cycle(16'h00c8, 7'h00);
        season_datapoint_type_i <= 1'b1;
        meas_temp_i <= 16'h0064;
        run_cycle(16'h00c8, 7'h64);
        cfg_i.pwm_mode <= 1'b0;
        cyc(3);
        check("pwm_cont", pwm_out_o, 1'b0);
        cfg_i.pwm_mode <= 1'b1;
    endtask

    task automatic t_integral();
        int k;
        int e;
        cfg_i.integral_time <= 9'h004;
        cfg_i.proportional_band <= REC_ELECTRIC_BAND;
        cfg_i.cycle_period <= REC_PERIOD_MAX;
        meas_temp_i <= 16'h00b4;
        do_reset();
        check("restored_sp", active_setpoint_o, 16'h00c8);
        run_cycle(16'h00c8, 7'h32);
        for (k = 1; k <= 5; k++)
        begin
            tick();
            e = (100 * (20 * 4 + 20 * k)) / (40 * 4);
            check("pct_integral", control_pct_o, (e > 100) ? 100 : e);
        end
    endtask

    task automatic t_pwm();
        int k;
        cfg_i.integral_time <= 9'h1ff;
        cfg_i.cycle_period <= 8'h04;
        do_reset();
        run_cycle(16'h00c8, 7'h32);
        check("pwm_start", pwm_out_o, 1'b1);
        for (k = 1; k <= 6; k++)
        begin
            tick();
            check("pwm_level", pwm_out_o, ((k % 4) * 100 < 50 * 4));
        end
        run_cycle(16'h00c8, 7'h32);
        check("pwm_restart", pwm_out_o, 1'b1);
    endtask

    task automatic t_modes();
        int m;
        for (m = 1; m <= 4; m++)
        begin
            setpoint_mode_i <= ptpwm_spmode_t'(m);
            cyc(3);
            check("mode_supported", mode_supported_o, 1'b0);
            write_sp(16'h0190, 1'b0);
            cyc(3);
            check("sp_kept", active_setpoint_o, 16'h00c8);
        end
        setpoint_mode_i <= SPM_SINGLE;
        cyc(3);
        check("mode_single", mode_supported_o, 1'b1);
    endtask

    task automatic t_window();
        int i;
        logic [5:0] w;
        for (i = 0; i < 64; i++)
        begin
            w = i[5:0];
            window_i <= w;
            cyc(3);
            check("window_open", window_open_o, |(w[5:4] & ~(w[3:2] ^ w[1:0])));
        end
        window_i <= 6'h10;
        cyc(4);
        check("protect_heat", active_setpoint_o, 16'h0046);
        write_sp(16'h0190, 1'b0);
        season_datapoint_type_i <= 1'b0;
        cyc(4);
        check("protect_cool", active_setpoint_o, 16'h015e);
        season_datapoint_type_i <= 1'b1;
        window_i <= 6'h00;
        cyc(4);
        check("frozen_sp", active_setpoint_o, 16'h00c8);
    endtask

    always @(posedge ref_clk_i)
    begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == LIMIT)
        begin
            bad_count++;
            stop_test();
        end
    end

    initial
    begin
        rstn_i = 1'b0;
        sample_tick_i = 1'b0;
        cfg_i = '{1'b1, 8'h28, 9'h1ff, 8'h04};
        setpoint_mode_i = SPM_SINGLE;
        presets_i = '{16'h00d2, 16'h0104, 16'h0046, 16'h015e};
        window_i = 6'h00;
        season_datapoint_type_i = 1'b1;
        setpoint_wr_i = 1'b0;
        setpoint_i = 16'h0000;
        meas_temp_i = 16'h00c8;
        do_reset();
        t_defaults();
        t_law();
        t_integral();
        t_pwm();
        t_modes();
        t_window();
        stop_test();
    end
endmodule

// >>> dv/ptpwm_core_checker.sv
// Concurrent checks on the ports of the PI thermostat
`timescale 1ns/100ps
module ptpwm_core_checker (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic sample_tick_i,
    input wire ptpwm_pkg::ptpwm_cfg_t cfg_i,
    input wire ptpwm_pkg::ptpwm_spmode_t setpoint_mode_i,
    input wire ptpwm_pkg::ptpwm_setpoints_t presets_i,
    input wire ptpwm_pkg::ptpwm_window_t window_i,
    input wire logic season_datapoint_type_i,
    input wire logic setpoint_wr_i,
    input wire logic signed [ptpwm_pkg::TEMP_W-1:0] setpoint_i,
    input wire logic signed [ptpwm_pkg::TEMP_W-1:0] meas_temp_i,
    input wire logic nv_valid_i,
    input wire logic signed [ptpwm_pkg::TEMP_W-1:0] nv_setpoint_i,
    input wire logic nv_store_o,
    input wire logic signed [ptpwm_pkg::TEMP_W-1:0] nv_data_o,
    input wire logic [ptpwm_pkg::CV_W-1:0] control_pct_o,
    input wire logic pwm_out_o,
    input wire logic cycle_start_o,
    input wire logic window_open_o,
    input wire logic mode_supported_o,
    input wire logic signed [ptpwm_pkg::TEMP_W-1:0] active_setpoint_o
);
    import ptpwm_pkg::*;
    logic open_any;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    assign open_any = |(window_i.enable & ~(window_i.normally_closed ^ window_i.contact_closed));

    chk_write_stored: assert property (setpoint_wr_i && setpoint_mode_i == SPM_SINGLE
        && !window_open_o && $stable(window_i) && $past(rstn_i)
        |=> nv_store_o && nv_data_o == $past(setpoint_i)) else $error("write not stored");
    chk_write_refused: assert property (setpoint_wr_i && setpoint_mode_i != SPM_SINGLE
        |=> !nv_store_o) else $error("write taken outside single mode");
    chk_setpoint_used: assert property (nv_store_o && !window_open_o ##1 !window_open_o
        |-> active_setpoint_o == $past(nv_data_o)) else $error("setpoint not applied");
    chk_pct_range: assert property (control_pct_o <= CV_FULL)
        else $error("control variable above full scale");
    chk_cont_pwm_off: assert property (!cfg_i.pwm_mode && !$past(cfg_i.pwm_mode)
        |-> !pwm_out_o) else $error("pwm output in continuous mode");
    chk_cycle_first_on: assert property (cycle_start_o && cfg_i.pwm_mode
        |-> ##[1:2] pwm_out_o == (control_pct_o != CV_RESET)) else $error("cycle start level");
    chk_restart_write: assert property (nv_store_o && cfg_i.pwm_mode
        |-> ##[1:80] cycle_start_o) else $error("no restart after write");
    chk_window_or: assert property ($past(rstn_i) |-> window_open_o == $past(open_any))
        else $error("window state wrong");
    chk_window_protect: assert property ((window_open_o && $stable(season_datapoint_type_i))[*3]
        |-> active_setpoint_o == (season_datapoint_type_i ? presets_i.protect_heat
        : presets_i.protect_cool)) else $error("protection setpoint not applied");
endmodule

bind ptpwm_core ptpwm_core_checker u_chk (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .sample_tick_i(sample_tick_i), .cfg_i(cfg_i), .setpoint_mode_i(setpoint_mode_i),
    .presets_i(presets_i), .window_i(window_i), .season_datapoint_type_i(season_datapoint_type_i),
    .setpoint_wr_i(setpoint_wr_i), .setpoint_i(setpoint_i), .meas_temp_i(meas_temp_i),
    .nv_valid_i(nv_valid_i), .nv_setpoint_i(nv_setpoint_i), .nv_store_o(nv_store_o),
    .nv_data_o(nv_data_o), .control_pct_o(control_pct_o), .pwm_out_o(pwm_out_o),
    .cycle_start_o(cycle_start_o), .window_open_o(window_open_o),
    .mode_supported_o(mode_supported_o), .active_setpoint_o(active_setpoint_o));

// >>> dv/ptpwm_nvm_model.sv
// Non-volatile setpoint store on the far side of the thermostat
`timescale 1ns/100ps
module ptpwm_nvm_model (
    input wire logic ref_clk_i,
    input wire logic store_i,
    input wire logic signed [ptpwm_pkg::TEMP_W-1:0] data_i,
    output logic valid_o,
    output logic signed [ptpwm_pkg::TEMP_W-1:0] data_o
);
    import ptpwm_pkg::*;
    logic signed [TEMP_W-1:0] mem_reg = 16'sh0000;
    logic [TEMP_W-1:0] junk_reg = 16'ha5a5;
    logic valid_reg = 1'b0;

    // No reset input: contents survive a reset of the thermostat
    always @(posedge ref_clk_i)
    begin
        junk_reg <= ~junk_reg;
        if (store_i)
        begin
            mem_reg <= data_i;
            valid_reg <= 1'b1;
        end
    end

    // Unwritten store shows a changing pattern, never a stale value
    assign valid_o = valid_reg;
    assign data_o = valid_reg ? mem_reg : junk_reg;
endmodule

// >>> src/ptpwm_core.sv
// PI room temperature controller with continuous and PWM outputs
`timescale 1ns/100ps

module ptpwm_core (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic sample_tick_i,
    input wire ptpwm_pkg::ptpwm_cfg_t cfg_i,
    input wire ptpwm_pkg::ptpwm_spmode_t setpoint_mode_i,
    input wire ptpwm_pkg::ptpwm_setpoints_t presets_i,
    input wire ptpwm_pkg::ptpwm_window_t window_i,
    input wire logic season_datapoint_type_i,
    input wire logic setpoint_wr_i,
    input wire logic signed [ptpwm_pkg::TEMP_W-1:0] setpoint_i,
    input wire logic signed [ptpwm_pkg::TEMP_W-1:0] meas_temp_i,
    input wire logic nv_valid_i,
    input wire logic signed [ptpwm_pkg::TEMP_W-1:0] nv_setpoint_i,
    output logic nv_store_o,
    output logic signed [ptpwm_pkg::TEMP_W-1:0] nv_data_o,
    output logic [ptpwm_pkg::CV_W-1:0] control_pct_o,
    output logic pwm_out_o,
    output logic cycle_start_o,
    output logic window_open_o,
    output logic mode_supported_o,
    output logic signed [ptpwm_pkg::TEMP_W-1:0] active_setpoint_o
);
    import ptpwm_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [BAND_W-1:0] nz_band(input logic [BAND_W-1:0] v);
        nz_band = (v == '0) ? 8'h01 : v;
    endfunction

    function automatic logic [ITIME_W-1:0] nz_time(input logic [ITIME_W-1:0] v);
        nz_time = (v == '0) ? 9'h001 : v;
    endfunction

    function automatic logic [PERIOD_W-1:0] nz_period(input logic [PERIOD_W-1:0] v);
        nz_period = (v == '0) ? 8'h01 : v;
    endfunction

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_DIV = 3'b010,
        ST_LOAD = 3'b100
    } ptpwm_state_t;

    ptpwm_state_t state_reg;
    logic signed [TEMP_W-1:0] sp_store_reg;
    logic sp_valid_reg;
    logic restore_done_reg;
    logic signed [ACC_W-1:0] acc_reg;
    logic [CV_W-1:0] cv_reg;
    logic [PERIOD_W-1:0] cnt_reg;
    logic calc_pend_reg;
    logic restart_pend_reg;
    logic restart_cur_reg;
    logic neg_num_reg;
    logic pwm_reg;
    logic cycle_start_reg;
    logic window_reg;
    logic supported_reg;
    logic signed [TEMP_W-1:0] active_sp_reg;
    logic nv_store_reg;
    logic signed [TEMP_W-1:0] nv_data_reg;

    logic [BAND_W-1:0] band_eff;
    logic [ITIME_W-1:0] itime_eff;
    logic [PERIOD_W-1:0] period_eff;
    logic window_open;
    logic sp_accept;
    logic signed [TEMP_W-1:0] sp_next;
    logic signed [ERR_W-1:0] err;
    logic signed [ACC_W-1:0] acc_lim;
    logic signed [ACC_W-1:0] acc_sum;
    logic signed [ACC_W-1:0] acc_next;
    logic signed [NUM_W-1:0] num;
    logic [DEN_W-1:0] den;
    logic div_start;
    logic div_done;
    logic [NUM_W-1:0] quo;
    logic cycle_wrap;
    logic [PERIOD_W+CV_W-1:0] on_limit;
    logic [PERIOD_W+CV_W-1:0] pos_scaled;

    assign band_eff = nz_band(cfg_i.proportional_band);
    assign itime_eff = nz_time(cfg_i.integral_time);
    assign period_eff = nz_period(cfg_i.cycle_period);

    // ------------------------------------------------------------
    // Window and setpoint selection
    // ------------------------------------------------------------
    // Normally closed contact: closed means open window
    assign window_open = |(window_i.enable &
        ~(window_i.contact_closed ^ window_i.normally_closed));

    // Only the bus object in single mode may change the setpoint, frozen while open
    assign sp_accept = setpoint_wr_i && (setpoint_mode_i == SPM_SINGLE)
        && !window_open;

    always_comb
    begin
        if (window_open)
        begin
            sp_next = season_datapoint_type_i ? presets_i.protect_heat
                : presets_i.protect_cool;
        end
        else if (sp_valid_reg)
        begin
            sp_next = sp_store_reg;
        end
        else
        begin
            sp_next = season_datapoint_type_i ? presets_i.default_heat
                : presets_i.default_cool;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            window_reg <= 1'b0;
            active_sp_reg <= SP_RESET;
            supported_reg <= 1'b0;
        end
        else
        begin
            window_reg <= window_open;
            active_sp_reg <= sp_next;
            supported_reg <= (setpoint_mode_i == SPM_SINGLE);
        end
    end

    // ------------------------------------------------------------
    // Stored setpoint and non-volatile copy
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            sp_store_reg <= SP_RESET;
            sp_valid_reg <= 1'b0;
            restore_done_reg <= 1'b0;
            nv_store_reg <= 1'b0;
            nv_data_reg <= SP_RESET;
        end
        else
        begin
            restore_done_reg <= 1'b1;
            nv_store_reg <= sp_accept;
            if (sp_accept)
            begin
                sp_store_reg <= setpoint_i;
                sp_valid_reg <= 1'b1;
                nv_data_reg <= setpoint_i;
            end
            else if (!restore_done_reg && nv_valid_i)
            begin
                sp_store_reg <= nv_setpoint_i;
                sp_valid_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Error and integral term
    // ------------------------------------------------------------
    // Next setpoint, so a restart just after a write already works on it
    assign err = season_datapoint_type_i
        ? (ERR_W'(sp_next) - ERR_W'(meas_temp_i))
        : (ERR_W'(meas_temp_i) - ERR_W'(sp_next));

    // Anti-windup: integral alone never exceeds full scale
    assign acc_lim = signed'(ACC_W'(band_eff) * ACC_W'(itime_eff));
    assign acc_sum = acc_reg + ACC_W'(err);

    always_comb
    begin
        if (acc_sum > acc_lim)
        begin
            acc_next = acc_lim;
        end
        else if (acc_sum < -acc_lim)
        begin
            acc_next = -acc_lim;
        end
        else
        begin
            acc_next = acc_sum;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            acc_reg <= ACC_RESET;
        end
        else if (sample_tick_i)
        begin
            acc_reg <= acc_next;
        end
    end

    // ------------------------------------------------------------
    // Control variable
    // ------------------------------------------------------------
    // cv = 100/band*err + 100/(band*itime)*acc, one shared division
    assign num = (NUM_W'(err) * NUM_W'(signed'({1'b0, itime_eff})) + NUM_W'(acc_reg))
        * NUM_SCALE;
    assign den = DEN_W'(band_eff) * DEN_W'(itime_eff);
    assign div_start = (state_reg == ST_IDLE) && (calc_pend_reg || restart_pend_reg);

    ptpwm_div u_div (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .start_i(div_start),
        .num_i(num[NUM_W-1] ? '0 : num),
        .den_i(den),
        .done_o(div_done),
        .quo_o(quo)
    );

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            state_reg <= ST_IDLE;
            neg_num_reg <= 1'b0;
            restart_cur_reg <= 1'b0;
        end
        else
        begin
            unique case (state_reg)
                ST_IDLE:
                begin
                    if (div_start)
                    begin
                        neg_num_reg <= num[NUM_W-1];
                        restart_cur_reg <= restart_pend_reg;
                        state_reg <= ST_DIV;
                    end
                end
                ST_DIV:
                begin
                    if (div_done)
                    begin
                        state_reg <= ST_LOAD;
                    end
                end
                ST_LOAD:
                begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Requests that arrive during a division are kept for the next one
    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            calc_pend_reg <= 1'b1;
            restart_pend_reg <= 1'b0;
        end
        else
        begin
            if (sample_tick_i)
            begin
                calc_pend_reg <= 1'b1;
            end
            else if (div_start)
            begin
                calc_pend_reg <= 1'b0;
            end
            if (sp_accept)
            begin
                restart_pend_reg <= 1'b1;
            end
            else if (div_start)
            begin
                restart_pend_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            cv_reg <= CV_RESET;
        end
        else if (state_reg == ST_LOAD)
        begin
            if (neg_num_reg)
            begin
                cv_reg <= CV_RESET;
            end
            else if (quo > NUM_W'(CV_FULL))
            begin
                cv_reg <= CV_FULL;
            end
            else
            begin
                cv_reg <= quo[CV_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Pulse cycle
    // ------------------------------------------------------------
    assign cycle_wrap = sample_tick_i && (cnt_reg >= period_eff - 8'h01);
    assign on_limit = (PERIOD_W+CV_W)'(cv_reg) * (PERIOD_W+CV_W)'(period_eff);
    assign pos_scaled = (PERIOD_W+CV_W)'(cnt_reg) * (PERIOD_W+CV_W)'(CV_FULL);

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            cnt_reg <= CNT_RESET;
            cycle_start_reg <= 1'b0;
        end
        else if ((state_reg == ST_LOAD) && restart_cur_reg)
        begin
            cnt_reg <= CNT_RESET;
            cycle_start_reg <= 1'b1;
        end
        else if (cycle_wrap)
        begin
            cnt_reg <= CNT_RESET;
            cycle_start_reg <= 1'b1;
        end
        else
        begin
            if (sample_tick_i)
            begin
                cnt_reg <= cnt_reg + 8'h01;
            end
            cycle_start_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            pwm_reg <= 1'b0;
        end
        else
        begin
            pwm_reg <= cfg_i.pwm_mode && (pos_scaled < on_limit);
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign nv_store_o = nv_store_reg;
    assign nv_data_o = nv_data_reg;
    assign control_pct_o = cv_reg;
    assign pwm_out_o = pwm_reg;
    assign cycle_start_o = cycle_start_reg;
    assign window_open_o = window_reg;
    assign mode_supported_o = supported_reg;
    assign active_setpoint_o = active_sp_reg;

endmodule

// >>> src/ptpwm_div.sv
// Sequential unsigned restoring divider used for the control variable
`timescale 1ns/100ps
module ptpwm_div (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic start_i,
    input wire logic [ptpwm_pkg::NUM_W-1:0] num_i,
    input wire logic [ptpwm_pkg::DEN_W-1:0] den_i,
    output logic done_o,
    output logic [ptpwm_pkg::NUM_W-1:0] quo_o
);
    import ptpwm_pkg::*;

    logic [NUM_W-1:0] quo_reg;
    logic [NUM_W-1:0] num_reg;
    logic [DEN_W:0] rem_reg;
    logic [DEN_W-1:0] den_reg;
    logic [5:0] cnt_reg;
    logic busy_reg;
    logic done_reg;
    logic [DEN_W:0] rem_shift;
    logic [DEN_W:0] rem_sub;

    assign rem_shift = {rem_reg[DEN_W-1:0], num_reg[NUM_W-1]};
    assign rem_sub = rem_shift - {1'b0, den_reg};

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            cnt_reg <= 6'h00;
            rem_reg <= '0;
            num_reg <= '0;
            den_reg <= '0;
            quo_reg <= '0;
        end
        else if (start_i)
        begin
            busy_reg <= 1'b1;
            done_reg <= 1'b0;
            cnt_reg <= 6'(NUM_W);
            rem_reg <= '0;
            num_reg <= num_i;
            den_reg <= den_i;
            quo_reg <= '0;
        end
        else if (busy_reg)
        begin
            num_reg <= {num_reg[NUM_W-2:0], 1'b0};
            if (!rem_sub[DEN_W])
            begin
                rem_reg <= rem_sub;
                quo_reg <= {quo_reg[NUM_W-2:0], 1'b1};
            end
            else
            begin
                rem_reg <= rem_shift;
                quo_reg <= {quo_reg[NUM_W-2:0], 1'b0};
            end
            cnt_reg <= cnt_reg - 6'h01;
            if (cnt_reg == 6'h01)
            begin
                busy_reg <= 1'b0;
                done_reg <= 1'b1;
            end
        end
        else
        begin
            done_reg <= 1'b0;
        end
    end

    assign done_o = done_reg;
    assign quo_o = quo_reg;

endmodule

// >>> src/ptpwm_pkg.sv
// Shared types and constants of the PI thermostat with PWM output
package ptpwm_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    // Temperatures are signed, in units of 0.1 K
    localparam int TEMP_W = 16;
    localparam int ERR_W = 17;
    // Proportional band in 0.1 K units
    localparam int BAND_W = 8;
    // Integral time in minutes
    localparam int ITIME_W = 9;
    // Pulse cycle period in sampling ticks (minutes)
    localparam int PERIOD_W = 8;
    localparam int CV_W = 7;
    localparam int ACC_W = 28;
    localparam int NUM_W = 40;
    localparam int DEN_W = 17;

    // ------------------------------------------------------------
    // Fixed numbers
    // ------------------------------------------------------------
    localparam logic [CV_W-1:0] CV_FULL = 7'h64;
    localparam logic signed [NUM_W-1:0] NUM_SCALE = 40'sh64;
    localparam logic [CV_W-1:0] CV_RESET = 7'h00;
    localparam logic [PERIOD_W-1:0] CNT_RESET = 8'h00;
    localparam logic signed [ACC_W-1:0] ACC_RESET = 28'sh0;
    localparam logic signed [TEMP_W-1:0] SP_RESET = 16'sh0;

    // ------------------------------------------------------------
    // Recommended commissioning sets (band in 0.1 K, time in min)
    // ------------------------------------------------------------
    localparam logic [BAND_W-1:0] REC_RADIATOR_BAND = 8'h32;
    localparam logic [ITIME_W-1:0] REC_RADIATOR_ITIME = 9'h096;
    localparam logic [BAND_W-1:0] REC_ELECTRIC_BAND = 8'h28;
    localparam logic [ITIME_W-1:0] REC_ELECTRIC_ITIME = 9'h064;
    localparam logic [BAND_W-1:0] REC_FANCOIL_BAND = 8'h28;
    localparam logic [ITIME_W-1:0] REC_FANCOIL_ITIME = 9'h05a;
    localparam logic [BAND_W-1:0] REC_FLOOR_BAND = 8'h32;
    localparam logic [ITIME_W-1:0] REC_FLOOR_ITIME = 9'h0f0;
    localparam logic [PERIOD_W-1:0] REC_PERIOD_MIN = 8'h0f;
    localparam logic [PERIOD_W-1:0] REC_PERIOD_MAX = 8'h14;
    localparam logic [PERIOD_W-1:0] REC_FAST_PERIOD_MIN = 8'h0a;
    localparam logic [PERIOD_W-1:0] REC_FAST_PERIOD_MAX = 8'h0f;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SPM_SINGLE = 3'h0,
        SPM_REL_BUS = 3'h1,
        SPM_REL_AUTO = 3'h2,
        SPM_ABS_BUS = 3'h3,
        SPM_ABS_AUTO = 3'h4
    } ptpwm_spmode_t;

    typedef struct packed {
        logic pwm_mode;
        logic [BAND_W-1:0] proportional_band;
        logic [ITIME_W-1:0] integral_time;
        logic [PERIOD_W-1:0] cycle_period;
    } ptpwm_cfg_t;

    typedef struct packed {
        logic signed [TEMP_W-1:0] default_heat;
        logic signed [TEMP_W-1:0] default_cool;
        logic signed [TEMP_W-1:0] protect_heat;
        logic signed [TEMP_W-1:0] protect_cool;
    } ptpwm_setpoints_t;

    typedef struct packed {
        logic [1:0] enable;
        logic [1:0] normally_closed;
        logic [1:0] contact_closed;
    } ptpwm_window_t;

endpackage
